// ==== hdl/ispp_pkg.sv ====
// Purpose: constants and carrier types for the signaling pre-processor
// Assumes: 200 MHz clk_i, APB register access
// Notes: contract list below
package ispp_pkg;
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_FIFO  = 8'h08;
  localparam logic [7:0] OFS_CMEM  = 8'h0C;
  localparam logic [7:0] OFS_BUF   = 8'h10;
  localparam logic [7:0] OFS_WPROT = 8'h14;
  localparam logic [7:0] OFS_MISC  = 8'h18;
  localparam logic [7:0] OFS_INTS  = 8'h1C;
  // control bit positions
  localparam int C_HRST = 0, C_FRST = 1, C_ATTENTION_REQUEST = 2, C_TEST = 3;
  localparam int C_IE = 4, C_TXDIS = 5, C_DRST = 6;
  localparam logic [6:0] CTRL_RST = 7'h00;
  // misc bit positions
  localparam int M_SANEN = 0, M_KICK = 1, M_DMA = 2, M_RXSEL = 3;
  localparam int M_SWRST = 4;
  // cmem write fields
  localparam int CM_TX = 10, CM_VAL = 16, CM_CH = 17;
  // buffer access fields
  localparam int B_DAT = 16, B_WE = 24, B_GO = 25;
  localparam int SLOTS = 640;
  localparam int CHANS = 32;
  localparam int CLK_NS = 5;
  localparam int FRAME_NS = 125000;
  localparam int TS_CYC = FRAME_NS / (SLOTS * CLK_NS);
  localparam int CH_CYC = FRAME_NS / (CHANS * CLK_NS);
  localparam int SAN_CYC = 2000000;
  localparam int BET_CYC = 64;
  localparam int WP_BLK_BITS = 10;
  localparam logic PAR_ODD = 1'b1;
  typedef struct packed {
    logic       valid;
    logic [4:0] chan;
  } ispp_cm_t;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ispp_hbuf_t;
  typedef enum logic [1:0] {
    AB_IDLE = 2'b00,
    AB_REQ  = 2'b01,
    AB_XFER = 2'b10,
    AB_DONE = 2'b11
  } ispp_ab_t;
endpackage

// ==== hdl/ispp_top.sv ====
// Purpose: speech bus interface, HDLC cell glue, processor complex glue
// Assumes: HDLC side and CPU memory bus share clk_i; pins are synced
// Notes: pready is always high, reads are registered in setup phase
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/100ps
module ispp_top #(
  parameter int CM_DEPTH   = 1024,
  parameter int FIFO_DEPTH = 1024,
  parameter int BUF_AW     = 16,
  parameter int SAN_CNT    = ispp_pkg::SAN_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [7:0]           paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  input  wire logic [7:0]           sb_rx0_i,
  input  wire logic [7:0]           sb_rx1_i,
  output logic      [7:0]           sb_tx_o,
  output logic                      sb_tx0_oe_o,
  output logic                      sb_tx1_oe_o,
  output logic      [9:0]           ts_o,
  output logic                      frame_o,
  output logic      [4:0]           hdlc_ch_o,
  output logic                      hdlc_ch_stb_o,
  output logic      [7:0]           hdlc_rx_data_o,
  input  wire logic                 hdlc_tx_we_i,
  input  wire logic [7:0]           hdlc_tx_data_i,
  input  wire ispp_pkg::ispp_hbuf_t hbuf_i,
  output logic      [7:0]           hbuf_rdata_o,
  input  wire logic                 hret_i,
  input  wire logic [4:0]           hret_ch_i,
  output logic                      hdlc_rst_o,
  output logic                      dch_rst_o,
  output logic                      attention_request_o,
  input  wire logic                 attention_acknowledge_i,
  output logic                      hdlc_irq_o,
  input  wire logic [3:0]           irq_ext_i,
  output logic      [2:0]           irq_lvl_o,
  input  wire logic                 mem_rd_i,
  input  wire logic                 mem_prog_i,
  input  wire logic [7:0]           mem_data_i,
  input  wire logic                 mem_par_i,
  output logic                      par_err_o,
  input  wire logic                 wp_we_i,
  input  wire logic [21:0]          wp_addr_i,
  output logic                      wp_ok_o,
  input  wire logic                 sp_rst_i,
  output logic                      card_rst_o,
  output logic                      san_tmo_o,
  output logic                      abus_req_o,
  input  wire logic                 abus_gnt_i,
  output logic                      abus_strb_o,
  input  wire logic                 abus_ack_i,
  output logic                      abus_berr_o
);
  import ispp_pkg::*;
  localparam int FW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(CM_DEPTH);

  function automatic logic [2:0] prio(input logic [6:0] s);
    prio = 3'h0;
    for (int i = 6; i >= 0; i--) begin
      if (s[i]) begin
        prio = 3'(7 - i);
      end
    end
  endfunction

  // pin synchroniser; stage one feeds stage two only
  logic [23:0] sy1_reg, sy2_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sy1_reg <= '0;
      sy2_reg <= '0;
    end else begin
      sy1_reg <= {sb_rx0_i, sb_rx1_i, attention_acknowledge_i, irq_ext_i,
                  sp_rst_i, abus_gnt_i, abus_ack_i};
      sy2_reg <= sy1_reg;
    end
  end
  logic [7:0] rx0_s, rx1_s;
  logic [3:0] ext_s;
  logic       attention_acknowledge_s, sprst_s, gnt_s, ack_s;
  assign {rx0_s, rx1_s, attention_acknowledge_s, ext_s, sprst_s, gnt_s, ack_s} = sy2_reg;

  logic acc, wr, rd;
  assign acc = psel_i & penable_i;
  assign wr  = acc & pwrite_i;
  assign rd  = acc & ~pwrite_i;
  logic swrst_reg, srst;
  assign srst = sprst_s | swrst_reg;

  // control register
  logic [6:0] ctrl_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= CTRL_RST;
    end else if (srst) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr && paddr_i == OFS_CTRL) begin
      ctrl_reg <= pwdata_i[6:0];
    end else begin
      ctrl_reg[C_FRST] <= 1'b0; // fifo reset is a one-shot
    end
  end
  assign hdlc_rst_o = ctrl_reg[C_HRST];
  assign dch_rst_o  = ctrl_reg[C_DRST];
  assign attention_request_o     = ctrl_reg[C_ATTENTION_REQUEST];

  // timeslot and channel counters
  logic [9:0] ts_reg;
  logic [9:0] tdiv_reg;
  logic       tstb;
  assign tstb = (tdiv_reg == 10'(TS_CYC - 1));
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tdiv_reg <= '0;
      ts_reg   <= '0;
    end else if (tstb) begin
      tdiv_reg <= '0;
      ts_reg   <= (ts_reg == 10'(SLOTS - 1)) ? '0 : ts_reg + 10'h1;
    end else begin
      tdiv_reg <= tdiv_reg + 10'h1;
    end
  end
  assign ts_o    = ts_reg;
  assign frame_o = tstb && ts_reg == 10'(SLOTS - 1);

  logic [4:0]  ch_reg;
  logic [11:0] cdiv_reg;
  logic        cstb;
  assign cstb = (cdiv_reg == 12'(CH_CYC - 1));
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cdiv_reg <= '0;
      ch_reg   <= '0;
    end else if (cstb) begin
      cdiv_reg <= '0;
      ch_reg   <= ch_reg + 5'h1;
    end else begin
      cdiv_reg <= cdiv_reg + 12'h1;
    end
  end
  assign hdlc_ch_o     = ch_reg;
  assign hdlc_ch_stb_o = cstb;

  // connection memories; written by CPU only
  ispp_cm_t rcm[CM_DEPTH];
  ispp_cm_t tcm[CM_DEPTH];
  ispp_cm_t cmw;
  assign cmw = {pwdata_i[CM_VAL], pwdata_i[CM_CH+4:CM_CH]};
  // cleared so no slot drives the bus before software maps it
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < CM_DEPTH; i++) begin
        rcm[i] <= '0;
        tcm[i] <= '0;
      end
    end else if (wr && paddr_i == OFS_CMEM) begin
      if (pwdata_i[CM_TX]) begin
        tcm[pwdata_i[CW-1:0]] <= cmw;
      end else begin
        rcm[pwdata_i[CW-1:0]] <= cmw;
      end
    end
  end
  ispp_cm_t rce, tce;
  assign rce = rcm[CW'(ts_reg)];
  assign tce = tcm[CW'(ts_reg)];

  // data memories: speech bus side and HDLC side only
  logic [7:0] rdm[CHANS];
  logic [7:0] tdm[CHANS];
  logic       rxsel_reg;
  always_ff @(posedge clk_i) begin
    if (tstb && rce.valid) begin
      // single rx side selected
      rdm[rce.chan] <= rxsel_reg ? rx1_s : rx0_s;
    end
    if (hdlc_tx_we_i) begin
      tdm[ch_reg] <= hdlc_tx_data_i;
    end
  end
  logic [7:0] txb_reg, hrx_reg;
  logic       toe_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      txb_reg <= '0;
      toe_reg <= 1'b0;
      hrx_reg <= '0;
    end else begin
      if (tstb) begin
        txb_reg <= tce.valid ? tdm[tce.chan] : 8'h00;
        toe_reg <= tce.valid;
      end
      if (cstb) begin
        hrx_reg <= rdm[ch_reg];
      end
    end
  end
  assign sb_tx_o        = txb_reg;
  assign sb_tx0_oe_o    = toe_reg & ~ctrl_reg[C_TXDIS];
  assign sb_tx1_oe_o    = toe_reg & ~ctrl_reg[C_TXDIS];
  assign hdlc_rx_data_o = hrx_reg;

  // shared buffer RAM, HDLC side has priority
  logic [7:0]  bram[2**BUF_AW];
  logic        cgo_reg, cwe_reg;
  logic [15:0] cad_reg;
  logic [7:0]  cdt_reg, crd_reg, hrd_reg;
  logic        cgrant;
  assign cgrant = cgo_reg & ~hbuf_i.req;
  always_ff @(posedge clk_i) begin
    if (hbuf_i.req && hbuf_i.we) begin
      bram[hbuf_i.addr[BUF_AW-1:0]] <= hbuf_i.wdata;
    end else if (cgrant && cwe_reg) begin
      bram[cad_reg[BUF_AW-1:0]] <= cdt_reg;
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cgo_reg <= 1'b0;
      cwe_reg <= 1'b0;
      cad_reg <= '0;
      cdt_reg <= '0;
      crd_reg <= '0;
      hrd_reg <= '0;
    end else begin
      if (hbuf_i.req) begin
        hrd_reg <= bram[hbuf_i.addr[BUF_AW-1:0]];
      end
      if (wr && paddr_i == OFS_BUF && !cgo_reg) begin
        cgo_reg <= pwdata_i[B_GO];
        cwe_reg <= pwdata_i[B_WE];
        cad_reg <= pwdata_i[15:0];
        cdt_reg <= pwdata_i[B_DAT+7:B_DAT];
      end else if (cgrant) begin
        cgo_reg <= 1'b0;
        crd_reg <= bram[cad_reg[BUF_AW-1:0]];
      end
    end
  end
  assign hbuf_rdata_o = hrd_reg;

  // buffer-return queue
  logic [8:0]  fmem[FIFO_DEPTH];
  logic [FW:0] wp_reg, rp_reg, fcnt;
  logic        fempty, ffull, fhalf, fpush, fpop;
  assign fcnt   = wp_reg - rp_reg;
  assign fempty = (fcnt == '0);
  assign ffull  = (fcnt == (FW+1)'(FIFO_DEPTH));
  assign fhalf  = (fcnt >= (FW+1)'(FIFO_DEPTH / 2));
  // mode picks the writer
  assign fpush = ~ffull & (ctrl_reg[C_TEST]
                 ? (wr && paddr_i == OFS_FIFO)
                 : hret_i);
  assign fpop  = rd && paddr_i == OFS_FIFO && !fempty;
  always_ff @(posedge clk_i) begin
    if (fpush) begin
      fmem[wp_reg[FW-1:0]] <= ctrl_reg[C_TEST] ? pwdata_i[8:0]
                              : {4'h0, hret_ch_i};
    end
  end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else if (srst || ctrl_reg[C_FRST]) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (fpush) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (fpop) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
  assign hdlc_irq_o = ctrl_reg[C_IE] & ~fempty;

  // misc: sanity, dma request, rx side, software reset
  logic        sanen_reg, dma_reg, san_reg;
  logic [31:0] scnt_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sanen_reg <= 1'b0;
      dma_reg   <= 1'b0;
      rxsel_reg <= 1'b0;
      swrst_reg <= 1'b0;
      scnt_reg  <= '0;
      san_reg   <= 1'b0;
    end else begin
      swrst_reg <= wr && paddr_i == OFS_MISC && pwdata_i[M_SWRST];
      if (wr && paddr_i == OFS_MISC) begin
        sanen_reg <= pwdata_i[M_SANEN];
        dma_reg   <= pwdata_i[M_DMA];
        rxsel_reg <= pwdata_i[M_RXSEL];
      end
      if (!sanen_reg || (wr && paddr_i == OFS_MISC && pwdata_i[M_KICK])) begin
        scnt_reg <= '0;
        san_reg  <= 1'b0;
      end else if (scnt_reg == 32'(SAN_CNT - 1)) begin
        san_reg <= 1'b1;
      end else begin
        scnt_reg <= scnt_reg + 32'h1;
      end
    end
  end
  assign san_tmo_o  = san_reg;
  assign card_rst_o = srst;

  // parity check on program reads; set wins over clear
  logic perr_reg, pbad;
  assign pbad = mem_rd_i & mem_prog_i & ((^mem_data_i ^ mem_par_i) != PAR_ODD);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      perr_reg <= 1'b0;
    end else if (pbad) begin
      perr_reg <= 1'b1;
    end else if (wr && paddr_i == OFS_INTS && pwdata_i[0]) begin
      perr_reg <= 1'b0;
    end
  end
  assign par_err_o = perr_reg;
  assign irq_lvl_o = prio({ext_s, 1'b0, perr_reg, san_reg});

  // write protection, one map bit per 1K block
  logic [31:0] wmap_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wmap_reg <= '0;
    end else if (wr && paddr_i == OFS_WPROT) begin
      wmap_reg <= pwdata_i;
    end
  end
  logic [11:0] blk;
  assign blk     = wp_addr_i[21:WP_BLK_BITS];
  assign wp_ok_o = ~wp_we_i | (blk > 12'h01F)
                   | ~wmap_reg[blk[4:0]];

  // A-bus master; SP keeps the bus unless we request
  ispp_ab_t    ab_reg;
  logic [7:0]  bet_reg;
  logic        berr_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ab_reg   <= AB_IDLE;
      bet_reg  <= '0;
      berr_reg <= 1'b0;
    end else begin
      case (ab_reg)
        AB_IDLE: begin
          if (dma_reg) begin
            ab_reg   <= AB_REQ;
            berr_reg <= 1'b0;
          end
        end
        AB_REQ: begin
          bet_reg <= '0;
          if (gnt_s) begin
            ab_reg <= AB_XFER;
          end
        end
        AB_XFER: begin
          bet_reg <= bet_reg + 8'h1;
          if (ack_s) begin
            ab_reg <= AB_DONE;
          end else if (bet_reg == 8'(BET_CYC - 1)) begin
            berr_reg <= 1'b1;
            ab_reg   <= AB_DONE;
          end
        end
        default: begin
          if (!dma_reg) begin
            ab_reg <= AB_IDLE;
          end
        end
      endcase
    end
  end
  assign abus_req_o  = (ab_reg == AB_REQ) || (ab_reg == AB_XFER);
  assign abus_strb_o = (ab_reg == AB_XFER);
  assign abus_berr_o = berr_reg;

  // APB read path; captured in setup phase
  logic [31:0] rdat_reg;
  logic        err_reg, mapped;
  assign mapped = paddr_i[7:5] == 3'h0 && paddr_i[1:0] == 2'h0;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdat_reg <= '0;
      err_reg  <= 1'b0;
    end else if (psel_i && !penable_i) begin
      err_reg <= ~mapped;
      if (paddr_i == OFS_CTRL) begin
        rdat_reg <= {25'h0, ctrl_reg};
      end else if (paddr_i == OFS_STAT) begin
        rdat_reg <= {28'h0, attention_acknowledge_s, ffull, fhalf, ~fempty};
      end else if (paddr_i == OFS_FIFO) begin
        rdat_reg <= {~fempty, 22'h0,
                     fempty ? 9'h000 : fmem[rp_reg[FW-1:0]]};
      end else if (paddr_i == OFS_BUF) begin
        rdat_reg <= {6'h0, cgo_reg, 17'h0, crd_reg};
      end else if (paddr_i == OFS_WPROT) begin
        rdat_reg <= wmap_reg;
      end else if (paddr_i == OFS_MISC) begin
        rdat_reg <= {26'h0, berr_reg, 1'b0, rxsel_reg, dma_reg,
                     1'b0, sanen_reg};
      end else if (paddr_i == OFS_INTS) begin
        rdat_reg <= {27'h0, irq_lvl_o, perr_reg, san_reg};
      end else begin
        rdat_reg <= '0;
      end
    end
  end
  assign prdata_o  = rdat_reg;
  assign pslverr_o = err_reg & acc;
  assign pready_o  = 1'b1;

  a_ts_wrap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tstb && ts_reg == 10'(SLOTS - 1) |=> ts_reg == 10'h000)
    else $error("slot wrap");
  a_ts_step: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !tstb |=> $stable(ts_reg)) else $error("slot moved");
  a_tx_slot: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tstb && !tce.valid |=> !sb_tx0_oe_o) else $error("tx off slot");
  a_tx_dis: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_reg[C_TXDIS] |-> !sb_tx0_oe_o && !sb_tx1_oe_o)
    else $error("tx not off");
  a_ch_wrap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cstb && ch_reg == 5'h1F |=> ch_reg == 5'h00)
    else $error("ch wrap");
  a_buf_prio: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hbuf_i.req && cgo_reg |=> cgo_reg) else $error("cpu beat hdlc");
  a_fifo_push: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    hret_i && !ctrl_reg[C_TEST] && !ffull && !srst && !ctrl_reg[C_FRST]
    |=> wp_reg == $past(wp_reg) + 1'b1) else $error("no push");
  a_fifo_empty: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rd && paddr_i == OFS_FIFO && fempty |=> rp_reg == $past(rp_reg))
    else $error("empty pop");
  a_fifo_test: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ctrl_reg[C_TEST] && hret_i && !wr && !srst && !ctrl_reg[C_FRST]
    |=> $stable(wp_reg)) else $error("test push");
  a_irq_top: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    san_reg |-> irq_lvl_o == 3'h7)
    else $error("sanity not top");
  a_par_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pbad |=> perr_reg && irq_lvl_o >= 3'h6)
    else $error("parity lost");
  a_san_off: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !sanen_reg |=> !san_reg) else $error("sanity while off");
  a_bet_end: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ab_reg == AB_XFER |-> ##[0:64] ab_reg != AB_XFER)
    else $error("bus hang");
  a_sp_default: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(abus_strb_o) |-> $past(gnt_s))
    else $error("strobe before grant");
  c_frame: cover property (@(posedge clk_i) frame_o);
  c_fifo_full: cover property (@(posedge clk_i) ffull);
  c_berr: cover property (@(posedge clk_i) $rose(berr_reg));
  c_contend: cover property (@(posedge clk_i) hbuf_i.req && cgo_reg);
endmodule

// ==== verif/ispp_far_model.sv ====
// Purpose: far side model, A-bus arbiter and agent, HDLC attention
// Assumes: same clock as the block; slow_i withholds every ack
// Notes: grant only while asked, otherwise the SP stays master
`timescale 1ns/100ps
module ispp_far_model (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic slow_i,
  input  wire logic abus_req_i,
  input  wire logic abus_strb_i,
  input  wire logic attention_request_i,
  output logic      abus_gnt_o,
  output logic      abus_ack_o,
  output logic      attention_acknowledge_o
);
  logic [3:0] req_reg;
  logic [3:0] stb_reg;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_reg <= 4'h0;
      stb_reg <= 4'h0;
      attention_acknowledge_o <= 1'b0;
    end else begin
      req_reg <= {req_reg[2:0], abus_req_i};
      stb_reg <= {stb_reg[2:0], abus_strb_i & ~slow_i};
      attention_acknowledge_o <= attention_request_i;
    end
  end
  // dropped at once with the request, never a stale grant
  assign abus_gnt_o = req_reg[3] & abus_req_i;
  assign abus_ack_o = stb_reg[3] & abus_strb_i;
endmodule

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench for the signaling pre-processor
// Assumes: small FIFO and sanity counts to keep the run short
// Notes: APB reads are queued and judged by a monitor process
`timescale 1ns/100ps
module tb_top;
  import ispp_pkg::*;
  typedef struct packed {
    logic        err;
    logic [31:0] m;
    logic [31:0] e;
  } ispp_exp_t;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic        hdlc_tx_we_i = 1'b0, hret_i = 1'b0, mem_rd_i = 1'b0;
  logic        mem_prog_i = 1'b0, mem_par_i = 1'b0, wp_we_i = 1'b0;
  logic        sp_rst_i = 1'b0, slow_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00, sb_rx0_i = 8'h00, sb_rx1_i = 8'h00;
  logic [7:0]  hdlc_tx_data_i = 8'h00, mem_data_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [4:0]  hret_ch_i = 5'h00;
  logic [3:0]  irq_ext_i = 4'h0;
  logic [21:0] wp_addr_i = 22'h0;
  ispp_hbuf_t  hbuf_i = '0;
  logic [31:0] prdata_o;
  logic [7:0]  sb_tx_o, hdlc_rx_data_o, hbuf_rdata_o;
  logic [9:0]  ts_o, t;
  logic [4:0]  hdlc_ch_o, ch;
  logic [2:0]  irq_lvl_o;
  logic        pready_o, pslverr_o, sb_tx0_oe_o, sb_tx1_oe_o, frame_o;
  logic        hdlc_ch_stb_o, hdlc_rst_o, dch_rst_o, attention_request_o, hdlc_irq_o;
  logic        par_err_o, wp_ok_o, card_rst_o, san_tmo_o, abus_req_o;
  logic        abus_strb_o, abus_berr_o, abus_gnt_i, abus_ack_i, attention_acknowledge_i;
  logic [15:0] a;
  logic [8:0]  v;
  logic [7:0]  d;
  logic [4:0]  ch_q[$];
  ispp_exp_t   exp_q[$];
  ispp_exp_t   cur;
  int          bad_count = 0, comparisons = 0, n, seed;

  ispp_top #(.FIFO_DEPTH(16), .SAN_CNT(50)) u_dut (.*);
  ispp_far_model u_far (.clk_i, .sys_rst_i, .slow_i,
    .abus_req_i(abus_req_o), .abus_strb_i(abus_strb_o), .attention_request_i(attention_request_o),
    .abus_gnt_o(abus_gnt_i), .abus_ack_o(abus_ack_i), .attention_acknowledge_o(attention_acknowledge_i));

  always #2.5 clk_i = ~clk_i;

  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= ad;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e, m);
    exp_q.push_back({ad > OFS_INTS || ad[1:0] != 2'b00, m, e});
    apb(1'b0, ad, 32'h0);
  endtask
  task automatic memrd(input logic p, q, e);
    mem_prog_i <= p;
    mem_par_i  <= q;
    mem_rd_i   <= 1'b1;
    @(posedge clk_i);
    mem_rd_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("parity", 32'(e), 32'(par_err_o));
  endtask
  task automatic print_verdict;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_i) begin
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
      cur = exp_q.pop_front();
      chk("prdata", cur.e, prdata_o & cur.m);
      chk("pslverr", 32'(cur.err), 32'(pslverr_o));
    end
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    bad_count++;
    print_verdict;
  end

  initial begin
    seed = $urandom(86112);
    sb_rx0_i <= 8'($urandom);
    sb_rx1_i <= 8'($urandom);
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(OFS_STAT, 32'h0, 32'hF);
    rd(8'h20, 32'h0, 32'hFFFFFFFF);
    rd(8'h06, 32'h0, 32'hFFFFFFFF);
    repeat (100) @(posedge clk_i);
    chk("sanity off", 32'h0, 32'(san_tmo_o));
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, OFS_CTRL, 32'h1 << k);
      repeat (8) @(posedge clk_i);
      chk("ctrl", 32'({k == C_HRST, k == C_ATTENTION_REQUEST, k == C_DRST}),
          32'({hdlc_rst_o, attention_request_o, dch_rst_o}));
      rd(OFS_STAT, 32'(k == C_ATTENTION_REQUEST) << 3, 32'h8);
    end
    // one push past full must be dropped
    apb(1'b1, OFS_CTRL, 32'h1 << C_IE);
    for (int i = 0; i < 17; i++) begin
      ch = 5'($urandom);
      if (i < 16) ch_q.push_back(ch);
      @(posedge clk_i);
      hret_ch_i <= ch;
      hret_i    <= 1'b1;
      @(posedge clk_i);
      hret_i <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
    chk("hdlc irq", 32'h1, 32'(hdlc_irq_o));
    rd(OFS_STAT, 32'h7, 32'h7);
    while (ch_q.size() > 0)
      rd(OFS_FIFO, {1'b1, 26'h0, ch_q.pop_front()}, 32'h800001FF);
    rd(OFS_FIFO, 32'h0, 32'h80000000);
    rd(OFS_STAT, 32'h0, 32'h7);
    v = 9'($urandom);
    apb(1'b1, OFS_CTRL, 32'h1 << C_TEST);
    @(posedge clk_i);
    hret_i <= 1'b1;
    @(posedge clk_i);
    hret_i <= 1'b0;
    apb(1'b1, OFS_FIFO, {23'h0, v});
    rd(OFS_FIFO, {1'b1, 22'h0, v}, 32'h800001FF);
    for (int i = 0; i < 4; i++) begin
      irq_ext_i <= 4'h1 << i;
      repeat (4) @(posedge clk_i);
      chk("level", 32'(4 - i), 32'(irq_lvl_o));
    end
    irq_ext_i  <= 4'hF;
    d = 8'($urandom);
    mem_data_i <= d;
    memrd(1'b0, ^d, 1'b0);
    memrd(1'b1, ~^d, 1'b0);
    memrd(1'b1, ^d, 1'b1);
    chk("level", 32'h6, 32'(irq_lvl_o));
    apb(1'b1, OFS_MISC, 32'h1 << M_SANEN);
    repeat (80) @(posedge clk_i);
    chk("level", 32'h7, 32'(irq_lvl_o));
    apb(1'b1, OFS_MISC, 32'h0);
    apb(1'b1, OFS_INTS, 32'h1);
    apb(1'b1, OFS_WPROT, 32'h2);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      wp_addr_i <= {12'(i == 0 ? 1 : i == 1 ? 2 : 33), 10'($urandom)};
      wp_we_i   <= 1'b1;
      @(negedge clk_i);
      chk("write ok", 32'(i != 0), 32'(wp_ok_o));
    end
    wp_we_i <= 1'b0;
    a = 16'($urandom);
    apb(1'b1, OFS_BUF, {6'h0, 2'b11, d, a});
    repeat (4) @(posedge clk_i);
    hbuf_i <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clk_i);
    hbuf_i <= '{1'b1, 1'b1, ~a, ~d};
    @(negedge clk_i);
    chk("hbuf read", 32'(d), 32'(hbuf_rdata_o));
    @(posedge clk_i);
    apb(1'b1, OFS_BUF, {6'h0, 2'b10, 8'h00, ~a});
    rd(OFS_BUF, 32'h02000000, 32'h02000000);
    hbuf_i.req <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(OFS_BUF, {24'h0, ~d}, 32'h020000FF);
    for (int i = 0; i < 2; i++) begin
      slow_i <= i[0];
      apb(1'b1, OFS_MISC, 32'h1 << M_DMA);
      repeat (150) @(posedge clk_i);
      chk("abus berr", 32'(i), 32'(abus_berr_o));
      rd(OFS_MISC, 32'(i) << 5, 32'h20);
      apb(1'b1, OFS_MISC, 32'h0);
      repeat (4) @(posedge clk_i);
      chk("abus req", 32'h0, 32'(abus_req_o));
    end
    // hdlc byte out in slot n, bus byte in to channel ch+2
    @(posedge clk_i);
    hdlc_tx_we_i   <= 1'b1;
    hdlc_tx_data_i <= d;
    @(negedge clk_i);
    ch = hdlc_ch_o;
    n  = (int'(ts_o) + 3) % SLOTS;
    @(posedge clk_i);
    hdlc_tx_we_i <= 1'b0;
    apb(1'b1, OFS_CMEM, (32'(ch) << CM_CH) | (32'h1 << CM_VAL)
        | (32'h1 << CM_TX) | 32'(n));
    apb(1'b1, OFS_CMEM, (32'(5'(ch + 5'h2)) << CM_CH)
        | (32'h1 << CM_VAL) | 32'(n));
    @(negedge clk_i iff ts_o == 10'((n + 1) % SLOTS));
    chk("tx byte", 32'(d), 32'(sb_tx_o));
    chk("tx sides", 32'h3, 32'({sb_tx0_oe_o, sb_tx1_oe_o}));
    @(negedge clk_i iff hdlc_ch_o == 5'(ch + 5'h3));
    chk("rx byte", 32'(sb_rx0_i), 32'(hdlc_rx_data_o));
    @(negedge clk_i iff hdlc_ch_stb_o);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (!hdlc_ch_stb_o && n < 2000);
    chk("chan gap", 32'(CH_CYC), 32'(n));
    t = ts_o;
    @(negedge clk_i iff ts_o != t);
    t = ts_o;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ts_o == t && n < 100);
    chk("slot gap", 32'(TS_CYC), 32'(n));
    chk("slot step", 32'(t == 10'(SLOTS - 1) ? 10'h000 : t + 10'h001),
        32'(ts_o));
    @(negedge clk_i iff frame_o);
    chk("frame slot", 32'(SLOTS - 1), 32'(ts_o));
    apb(1'b1, OFS_CTRL, 32'h1 << C_ATTENTION_REQUEST);
    sp_rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("card rst", 32'h1, 32'(card_rst_o));
    sp_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("attention_request cleared", 32'h0, 32'(attention_request_o));
    print_verdict;
  end
endmodule
